// File: fault_log_mem.sv
// fault log memory model with a stalling write port
`timescale 1ns/1ns
`default_nettype none
module fault_log_mem (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic log_wr_valid,
  input wire logic [31:0] log_wr_addr,
  input wire logic [127:0] log_wr_data,
  output var logic log_wr_ready,
  // stall control
  input wire logic slow
);
  // ======
  // storage
  logic [127:0] mem [logic [31:0]];
  integer seed = 32'h218a;
  // ready wanders when slow so that records wait on the port
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_wr_ready <= 1'b0;
    end else begin
      if (log_wr_valid && log_wr_ready) begin
        mem[log_wr_addr] = log_wr_data;
      end
      log_wr_ready <= !slow || (($random(seed) & 1) != 0);
    end
  end
endmodule
`default_nettype wire

// File: fault_log_port.sv
// holds one whole record on the log write port until it is taken
`timescale 1ns/1ns
`default_nettype none
module fault_log_port #(
  parameter int AW = 32
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // load side
  input wire logic load,
  input wire logic [AW-1:0] load_addr,
  input wire logic [127:0] load_data,
  output logic done,
  // memory side
  output logic log_wr_valid,
  output logic [AW-1:0] log_wr_addr,
  output logic [127:0] log_wr_data,
  input wire logic log_wr_ready
);
  typedef struct packed {
    logic valid;
    logic [AW-1:0] addr;
    logic [127:0] data;
  } port_type;

  port_type r_ff;
  port_type nxt_r;

  always_comb begin
    nxt_r = r_ff;
    if (r_ff.valid && log_wr_ready) begin
      nxt_r.valid = 1'b0;
    end
    // the word only moves while no write is pending, never piecewise
    if (load && !r_ff.valid) begin
      nxt_r.valid = 1'b1;
      nxt_r.addr = load_addr;
      nxt_r.data = load_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign done = r_ff.valid & log_wr_ready;
  assign log_wr_valid = r_ff.valid;
  assign log_wr_addr = r_ff.addr;
  assign log_wr_data = r_ff.data;
endmodule
`default_nettype wire

// File: fault_record_builder.sv
// fault record builder: intake, apb registers, log commit, interrupt
// Operation
// - access kind: write 0, read/atomic 1
// - copy request address type into field
// - no device-tlb support: address type zero
// - record pasid value in value field
// - flag pasid on translation faults; else zero (the code sets it only when has_pasid and pasid support are both on)
// - eight-bit cause code in every record
// - run flag when read asked execute
// - supervisor flag when privilege was requested
// - requester id into source tag field
// - translation fault: page address in detail
// - remap fault: index high, low detail clear
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module fault_record_builder #(
  parameter int AW = 32
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // faulted request
  input wire logic flt_valid,
  output logic flt_ready,
  input wire logic flt_is_xlate,
  input wire logic flt_is_read,
  input wire logic [1:0] flt_addr_type,
  input wire logic flt_has_pasid,
  input wire logic [19:0] flt_pasid,
  input wire logic [7:0] flt_cause,
  input wire logic flt_exec_req,
  input wire logic flt_supervisor_request_flag_req,
  input wire logic [15:0] flt_requester_id,
  input wire logic [51:0] flt_page_addr,
  input wire logic [15:0] flt_intr_index,
  // fault log write port
  output logic log_wr_valid,
  output logic [AW-1:0] log_wr_addr,
  output logic [127:0] log_wr_data,
  input wire logic log_wr_ready,
  // interrupt
  output logic irq
);
  // ==========================================================
  // state
  typedef struct packed {
    fault_record_pkg::intake_state_type st;
    logic flt_ready;
    logic [fault_record_pkg::CTRL_W-1:0] ctrl;
    logic [fault_record_pkg::STAT_W-1:0] stat;
    logic [fault_record_pkg::STAT_W-1:0] mask;
    logic [31:0] base;
    logic [31:0] count;
    logic [127:0] rec;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } regs_type;

  regs_type r_ff;
  regs_type nxt_r;
  logic [127:0] rec_fmt;
  logic log_done;
  logic load;
  logic take;
  logic access;
  logic wr;
  logic [fault_record_pkg::STAT_W-1:0] ev;

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a[1:0] == 2'b00) && (a <= fault_record_pkg::LAST3_OFS);
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] a, input regs_type s);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      fault_record_pkg::CTRL_OFS: v[fault_record_pkg::CTRL_W-1:0] = s.ctrl;
      fault_record_pkg::STAT_OFS: v[fault_record_pkg::STAT_W-1:0] = s.stat;
      fault_record_pkg::MASK_OFS: v[fault_record_pkg::STAT_W-1:0] = s.mask;
      fault_record_pkg::BASE_OFS: v = s.base;
      fault_record_pkg::COUNT_OFS: v = s.count;
      default: begin
        if (a >= fault_record_pkg::LAST0_OFS && reg_hit(a)) begin
          v = s.rec[32*((a - fault_record_pkg::LAST0_OFS) >> 2) +: 32];
        end
      end
    endcase
    return v;
  endfunction

  // ==========================================================
  // datapath
  fault_record_format u_format (
    .is_xlate(flt_is_xlate),
    .is_read(flt_is_read),
    .addr_type(flt_addr_type),
    .has_pasid(flt_has_pasid),
    .pasid(flt_pasid),
    .cause(flt_cause),
    .exec_req(flt_exec_req),
    .supervisor_request_flag_req(flt_supervisor_request_flag_req),
    .requester_id(flt_requester_id),
    .page_addr(flt_page_addr),
    .intr_index(flt_intr_index),
    .device_tlb_support(r_ff.ctrl[fault_record_pkg::DEVICE_TLB_SUPPORT_BIT]),
    .pasid_support(r_ff.ctrl[fault_record_pkg::PASID_SUPPORT_BIT]),
    .rec(rec_fmt)
  );

  fault_log_port #(
    .AW(AW)
  ) u_port (
    .pclk(pclk),
    .presetn(presetn),
    .load(load),
    .load_addr(AW'(r_ff.base + {r_ff.count[27:0], 4'h0})),
    .load_data(r_ff.rec),
    .done(log_done),
    .log_wr_valid(log_wr_valid),
    .log_wr_addr(log_wr_addr),
    .log_wr_data(log_wr_data),
    .log_wr_ready(log_wr_ready)
  );

  // ==========================================================
  // next state
  assign load = (r_ff.st == fault_record_pkg::ST_LOAD);
  assign take = flt_valid & r_ff.flt_ready;
  assign access = psel & penable;
  assign wr = access & r_ff.pready & pwrite & ~r_ff.pslverr;

  always_comb begin
    nxt_r = r_ff;
    ev = '0;
    case (r_ff.st)
      fault_record_pkg::ST_IDLE: begin
        if (take) begin
          if (r_ff.ctrl[fault_record_pkg::ENABLE_BIT]) begin
            nxt_r.rec = rec_fmt;
            nxt_r.st = fault_record_pkg::ST_LOAD;
          end else begin
            ev[fault_record_pkg::DROPPED_BIT] = 1'b1;
          end
        end
      end
      fault_record_pkg::ST_LOAD: begin
        nxt_r.st = fault_record_pkg::ST_WAIT;
      end
      fault_record_pkg::ST_WAIT: begin
        if (log_done) begin
          nxt_r.count = r_ff.count + 32'h0000_0001;
          ev[fault_record_pkg::LOGGED_BIT] = 1'b1;
          nxt_r.st = fault_record_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_r.st = fault_record_pkg::ST_IDLE;
      end
    endcase
    // one record in flight; the requester waits instead of losing faults
    nxt_r.flt_ready = (nxt_r.st == fault_record_pkg::ST_IDLE);

    // one wait state: pready rises in the second access cycle
    nxt_r.pready = access & ~r_ff.pready;
    if (access && !r_ff.pready) begin
      nxt_r.pslverr = ~reg_hit(paddr);
      nxt_r.prdata = pwrite ? 32'h0000_0000 : reg_read(paddr, r_ff);
    end
    if (wr) begin
      case (paddr)
        fault_record_pkg::CTRL_OFS: nxt_r.ctrl = pwdata[fault_record_pkg::CTRL_W-1:0];
        fault_record_pkg::STAT_OFS: nxt_r.stat = r_ff.stat & ~pwdata[fault_record_pkg::STAT_W-1:0];
        fault_record_pkg::MASK_OFS: nxt_r.mask = pwdata[fault_record_pkg::STAT_W-1:0];
        fault_record_pkg::BASE_OFS: nxt_r.base = pwdata;
        default: ;
      endcase
    end
    // set after clear, so a same-cycle event survives
    nxt_r.stat = nxt_r.stat | ev;
    nxt_r.irq = |(nxt_r.stat & nxt_r.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '0;
      r_ff.st <= fault_record_pkg::ST_IDLE;
      r_ff.flt_ready <= 1'b1;
      r_ff.ctrl <= fault_record_pkg::CTRL_RST;
      r_ff.stat <= fault_record_pkg::STAT_RST;
      r_ff.mask <= fault_record_pkg::MASK_RST;
      r_ff.base <= fault_record_pkg::BASE_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign flt_ready = r_ff.flt_ready;
  assign prdata = r_ff.prdata;
  assign pready = r_ff.pready;
  assign pslverr = r_ff.pslverr;
  assign irq = r_ff.irq;

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_take;
    r_ff.st == fault_record_pkg::ST_IDLE && take && r_ff.ctrl[0];
  endsequence
  sequence s_take_x;
    s_take ##0 flt_is_xlate;
  endsequence
  sequence s_take_p;
    s_take_x ##0 flt_has_pasid && r_ff.ctrl[2];
  endsequence

  property p_kind;
    s_take |=> r_ff.rec[126] == $past(flt_is_xlate & flt_is_read);
  endproperty
  a_kind: assert property (p_kind) else $error("access kind wrong");

  property p_atype;
    s_take_x ##0 r_ff.ctrl[1] |=> r_ff.rec[125:124] == $past(flt_addr_type);
  endproperty
  a_atype: assert property (p_atype) else $error("address type wrong");

  property p_atype_zero;
    s_take ##0 !r_ff.ctrl[1] |=> r_ff.rec[125:124] == 2'h0;
  endproperty
  a_atype_zero: assert property (p_atype_zero) else $error("address type not zero");

  property p_pasid;
    s_take_p |=> r_ff.rec[95] && r_ff.rec[123:104] == $past(flt_pasid);
  endproperty
  a_pasid: assert property (p_pasid) else $error("pasid value wrong");

  property p_pasid_off;
    s_take ##0 !r_ff.ctrl[2] |=> r_ff.rec[123:104] == 20'h0_0000 && r_ff.rec[95:93] == 3'h0;
  endproperty
  a_pasid_off: assert property (p_pasid_off) else $error("pasid fields not zero");

  property p_cause;
    s_take |=> r_ff.rec[103:96] == $past(flt_cause);
  endproperty
  a_cause: assert property (p_cause) else $error("cause code wrong");

  property p_flags;
    s_take_p |=> r_ff.rec[94] == $past(flt_exec_req & flt_is_read)
      && r_ff.rec[93] == $past(flt_supervisor_request_flag_req);
  endproperty
  a_flags: assert property (p_flags) else $error("run or supervisor flag wrong");

  property p_sid;
    s_take |=> r_ff.rec[79:64] == $past(flt_requester_id);
  endproperty
  a_sid: assert property (p_sid) else $error("source tag wrong");

  property p_detail;
    s_take |=> r_ff.rec[63:12] == ($past(flt_is_xlate) ? $past(flt_page_addr)
      : {$past(flt_intr_index), 36'h0_0000_0000});
  endproperty
  a_detail: assert property (p_detail) else $error("detail bits wrong");

  property p_rsv;
    log_wr_valid |-> !log_wr_data[127] && log_wr_data[92:80] == 13'h0000
      && log_wr_data[11:0] == 12'h000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");

  // port idle while the word is built, then the whole word at once
  property p_commit;
    s_take |=> !log_wr_valid ##1 log_wr_valid && log_wr_data == r_ff.rec;
  endproperty
  a_commit: assert property (p_commit) else $error("record not committed whole");

  property p_hold;
    log_wr_valid && !log_wr_ready |=> log_wr_valid && $stable(log_wr_data) && $stable(log_wr_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("record changed while pending");

  sequence s_drop;
    r_ff.st == fault_record_pkg::ST_IDLE && take && !r_ff.ctrl[0];
  endsequence
  sequence s_log_done;
    log_wr_valid && log_wr_ready;
  endsequence

  property p_busy;
    s_take |=> !flt_ready ##1 !flt_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("intake open with record in flight");

  property p_drop;
    s_drop |=> r_ff.stat[fault_record_pkg::DROPPED_BIT] && flt_ready && !log_wr_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("disabled fault not dropped");

  // address is fixed at load time, later base writes do not move it
  property p_log_addr;
    $rose(log_wr_valid) |->
      log_wr_addr == AW'($past(r_ff.base) + {$past(r_ff.count[27:0]), 4'h0});
  endproperty
  a_log_addr: assert property (p_log_addr) else $error("log address wrong");

  property p_log_done;
    s_log_done |=> r_ff.count == $past(r_ff.count) + 32'h0000_0001
      && r_ff.stat[fault_record_pkg::LOGGED_BIT] && flt_ready;
  endproperty
  a_log_done: assert property (p_log_done) else $error("commit not accounted");

  property p_irq;
    irq == |(r_ff.stat & r_ff.mask);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  property p_ready_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("apb answer late");

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("apb ready held too long");

  property p_err_data;
    pready && pslverr |-> prdata == 32'h0000_0000;
  endproperty
  a_err_data: assert property (p_err_data) else $error("refused read returned data");

  property p_err_addr;
    pready |-> pslverr == !reg_hit(paddr);
  endproperty
  a_err_addr: assert property (p_err_addr) else $error("apb error flag wrong");
endmodule
`default_nettype wire

// File: fault_record_builder_tb.sv
// self-checking testbench for the fault record builder
`timescale 1ns/1ns
`default_nettype none
module fault_record_builder_tb;
  // ======
  // signals
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic flt_valid = 0, flt_ready, flt_is_xlate = 0, flt_is_read = 0;
  logic [1:0] flt_addr_type = '0;
  logic flt_has_pasid = 0, flt_exec_req = 0, flt_supervisor_request_flag_req = 0;
  logic [19:0] flt_pasid = '0;
  logic [7:0] flt_cause = '0;
  logic [15:0] flt_requester_id = '0, flt_intr_index = '0;
  logic [51:0] flt_page_addr = '0;
  logic log_wr_valid, log_wr_ready, irq, slow = 0;
  logic [31:0] log_wr_addr;
  logic [127:0] log_wr_data, rnd, last;
  logic [31:0] base = '0, cnt = '0;
  logic [159:0] q[$];
  logic [32:0] aq[$];
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  integer seed = 32'h218a;

  fault_record_builder #(.AW(32)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .flt_valid, .flt_ready,
    .flt_is_xlate, .flt_is_read, .flt_addr_type, .flt_has_pasid, .flt_pasid,
    .flt_cause, .flt_exec_req, .flt_supervisor_request_flag_req, .flt_requester_id, .flt_page_addr,
    .flt_intr_index, .log_wr_valid, .log_wr_addr, .log_wr_data, .log_wr_ready, .irq);
  fault_log_mem mem (.pclk, .presetn, .log_wr_valid, .log_wr_addr, .log_wr_data,
    .log_wr_ready, .slow);

  initial begin
    forever #2 pclk = ~pclk;
  end

  // ======
  // checking and closing
  task automatic results();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(logic [159:0] g, logic [159:0] x);
    check_count++;
    if (g !== x) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  // reads the fault inputs while they are still held
  function automatic logic [127:0] expect_rec(logic tlb, logic ps);
    logic [127:0] r;
    r = '0;
    r[103:96] = flt_cause;
    r[79:64] = flt_requester_id;
    if (flt_is_xlate) begin
      r[126] = flt_is_read;
      if (tlb) r[125:124] = flt_addr_type;
      if (ps && flt_has_pasid) begin
        r[95] = 1'b1;
        r[123:104] = flt_pasid;
        r[94] = flt_exec_req & flt_is_read;
        r[93] = flt_supervisor_request_flag_req;
      end
      r[63:12] = flt_page_addr;
    end else begin
      r[63:48] = flt_intr_index;
    end
    return r;
  endfunction

  // ======
  // drivers
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [32:0] e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    aq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic send_fault(logic tlb, logic ps, logic en);
    flt_valid <= 1'b1;
    {flt_is_xlate, flt_is_read, flt_addr_type, flt_has_pasid, flt_exec_req, flt_supervisor_request_flag_req,
      flt_pasid, flt_cause, flt_requester_id, flt_page_addr, flt_intr_index} <= rnd[118:0];
    do @(posedge pclk); while (!flt_ready);
    if (en) begin
      last = expect_rec(tlb, ps);
      q.push_back({base + (cnt << 4), last});
      cnt++;
    end
    flt_valid <= 1'b0;
  endtask

  task automatic irq_is(logic v);
    repeat (2) @(posedge pclk);
    chk(160'(irq), 160'(v));
  endtask

  // ======
  // monitor
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      results();
    end
    if (psel && penable && pready) begin
      chk(160'({pslverr, pwrite ? 32'h0 : prdata}), 160'(aq.pop_front()));
    end
    if (log_wr_valid && log_wr_ready) begin
      chk({log_wr_addr, log_wr_data}, q.pop_front());
    end
  end

  // ======
  // sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // outputs at their reset levels right after release
    chk(160'({flt_ready, log_wr_valid, irq, pready, pslverr}), 160'(5'h10));
    for (int i = 0; i < 5; i++) begin
      apb(0, 8'(4 * i), 0, (i == 0) ? 33'(fault_record_pkg::CTRL_RST) : 33'h0);
    end
    // unmapped, unaligned and read-only places
    apb(0, 8'h24, 0, 33'h1_0000_0000);
    apb(0, 8'h02, 0, 33'h1_0000_0000);
    apb(1, 8'h30, 32'h0000_0007, 33'h1_0000_0000);
    apb(1, fault_record_pkg::COUNT_OFS, 32'h0000_0005, 33'h0);
    apb(0, fault_record_pkg::COUNT_OFS, 0, 33'h0);
    base = 32'h8000_1000;
    apb(1, fault_record_pkg::BASE_OFS, base, 33'h0);
    apb(1, fault_record_pkg::MASK_OFS, 32'h0000_0001, 33'h0);
    for (int i = 0; i < 24; i++) begin
      rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
      slow <= rnd[127];
      apb(1, fault_record_pkg::CTRL_OFS, {29'h0, rnd[121:120], 1'b1}, 33'h0);
      send_fault(rnd[120], rnd[121], 1'b1);
    end
    while (q.size() != 0) @(posedge pclk);
    apb(0, fault_record_pkg::COUNT_OFS, 0, {1'b0, cnt});
    apb(0, fault_record_pkg::STAT_OFS, 0, 33'h1);
    irq_is(1'b1);
    // last record words, whole record visible at once
    for (int i = 0; i < 4; i++) begin
      apb(0, fault_record_pkg::LAST0_OFS + 8'(4 * i), 0, {1'b0, last[32 * i +: 32]});
    end
    apb(1, fault_record_pkg::STAT_OFS, 32'h0000_0001, 33'h0);
    irq_is(1'b0);
    apb(0, fault_record_pkg::STAT_OFS, 0, 33'h0);
    // disabled: fault dropped, nothing written
    apb(1, fault_record_pkg::CTRL_OFS, 0, 33'h0);
    send_fault(1'b0, 1'b0, 1'b0);
    repeat (6) @(posedge pclk);
    apb(0, fault_record_pkg::STAT_OFS, 0, 33'h2);
    irq_is(1'b0);
    apb(1, fault_record_pkg::MASK_OFS, 32'h0000_0003, 33'h0);
    irq_is(1'b1);
    apb(1, fault_record_pkg::STAT_OFS, 32'h0000_0002, 33'h0);
    irq_is(1'b0);
    apb(0, fault_record_pkg::COUNT_OFS, 0, {1'b0, cnt});
    chk(160'(q.size()), 160'(0));
    results();
  end
endmodule
`default_nettype wire

// File: fault_record_format.sv
// packs the attributes of one fault into the 128-bit record
`timescale 1ns/1ns
`default_nettype none
module fault_record_format (
  // fault attributes
  input wire logic is_xlate,
  input wire logic is_read,
  input wire logic [1:0] addr_type,
  input wire logic has_pasid,
  input wire logic [19:0] pasid,
  input wire logic [7:0] cause,
  input wire logic exec_req,
  input wire logic supervisor_request_flag_req,
  input wire logic [15:0] requester_id,
  input wire logic [51:0] page_addr,
  input wire logic [15:0] intr_index,
  // capabilities
  input wire logic device_tlb_support,
  input wire logic pasid_support,
  // result
  output logic [127:0] rec
);
  logic pflag;

  always_comb begin
    // reserved positions stay at the zero set here
    rec = '0;
    pflag = is_xlate & has_pasid & pasid_support;
    rec[fault_record_pkg::ACCESS_KIND_BIT] = is_xlate & is_read;
    if (is_xlate && device_tlb_support) begin
      rec[fault_record_pkg::ADDR_TYPE_LO +: 2] = addr_type;
    end
    rec[fault_record_pkg::PROCESS_SPACE_FLAG_BIT] = pflag;
    if (pflag) begin
      rec[fault_record_pkg::PROCESS_SPACE_VALUE_LO +: 20] = pasid;
      rec[fault_record_pkg::RUN_PERMISSION_FLAG_BIT] = exec_req & is_read;
      rec[fault_record_pkg::SUPERVISOR_REQUEST_FLAG_BIT] = supervisor_request_flag_req;
    end
    rec[fault_record_pkg::FAULT_CAUSE_CODE_LO +: 8] = cause;
    rec[fault_record_pkg::REQUESTER_SOURCE_TAG_LO +: 16] = requester_id;
    if (is_xlate) begin
      rec[fault_record_pkg::FAULT_DETAIL_BITS_LO +: 52] = page_addr;
    end else begin
      rec[fault_record_pkg::INTR_INDEX_LO +: 16] = intr_index;
    end
  end
endmodule
`default_nettype wire

// File: fault_record_pkg.sv
// shared constants for the fault record builder
package fault_record_pkg;
  // ==========================================================
  // record layout
  localparam int REC_W = 128;
  localparam int RSV_TOP_BIT = 127;
  localparam int ACCESS_KIND_BIT = 126;
  localparam int ADDR_TYPE_LO = 124;
  localparam int PROCESS_SPACE_VALUE_LO = 104;
  localparam int FAULT_CAUSE_CODE_LO = 96;
  localparam int PROCESS_SPACE_FLAG_BIT = 95;
  localparam int RUN_PERMISSION_FLAG_BIT = 94;
  localparam int SUPERVISOR_REQUEST_FLAG_BIT = 93;
  localparam int RSV_MID_LO = 80;
  localparam int RSV_MID_HI = 92;
  localparam int REQUESTER_SOURCE_TAG_LO = 64;
  localparam int FAULT_DETAIL_BITS_LO = 12;
  localparam int INTR_INDEX_LO = 48;
  localparam int RSV_LOW_HI = 11;
  localparam int REC_BYTES_LOG2 = 4;

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] BASE_OFS = 8'h0c;
  localparam logic [7:0] COUNT_OFS = 8'h10;
  localparam logic [7:0] LAST0_OFS = 8'h14;
  localparam logic [7:0] LAST3_OFS = 8'h20;

  // control and status fields
  localparam int CTRL_W = 3;
  localparam int ENABLE_BIT = 0;
  localparam int DEVICE_TLB_SUPPORT_BIT = 1;
  localparam int PASID_SUPPORT_BIT = 2;
  localparam int STAT_W = 2;
  localparam int LOGGED_BIT = 0;
  localparam int DROPPED_BIT = 1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h1;
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
  localparam logic [STAT_W-1:0] MASK_RST = 2'h0;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_WAIT = 2'b10
  } intake_state_type;
endpackage
